// >>> qpd_top.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none
`include "qpd_defines.svh"

module qpd_top (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_b,
   input  wire qpd_pkg::qpd_apb_req_t apb_req,
   output qpd_pkg::qpd_apb_rsp_t      apb_rsp,
   input  wire logic                  phase_a_input,
   input  wire logic                  phase_b_input,
   input  wire logic                  index_input,
   input  wire logic                  cpu_sleep,
   output logic                       irq
);
   import qpd_pkg::*;

   qpd_st_t               st_ff;
   qpd_st_t               nxt_st;

   logic                  filt_a;
   logic                  filt_b;
   logic                  filt_i;
   logic                  tick;
   logic [`QPD_DIV_W-1:0] div_mask;
   logic                  sel_a;
   logic                  sel_b;
   logic                  sel_i;
   logic                  edge_a;
   logic                  edge_b;
   logic                  rise_a;
   logic                  rise_i;
   logic                  is_qei;
   logic                  idx_rst;
   logic                  max_rst;
   logic                  step;
   logic                  cnt_up;
   logic                  match_ev;
   logic                  index_ev;
   logic                  wr_en;
   logic                  rd_setup;
   logic                  dir_rd;
   logic [31:0]           rd_data;
   logic                  rd_err;
   logic [`QPD_ST_W-1:0]  st_set;
   logic [`QPD_ST_W-1:0]  st_clr;
   logic                  tmr_dir;
   logic                  step_ok;
   logic                  idx_ok;
   logic                  wrap_up;
   logic                  wrap_dn;
   logic [15:0]           pos_inc;
   logic [15:0]           pos_dec;

   // ****************************************************************
   // Input filters
   // ****************************************************************
   // Each filter watches the synchronised pin, never the raw pin.
   // The filters run while disabled too, so enabling them adds no stale history.
   qpd_filter u_filt_a (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .tick    (tick),
      .din     (st_ff.sync_a[1]),
      .dout    (filt_a)
   );

   qpd_filter u_filt_b (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .tick    (tick),
      .din     (st_ff.sync_b[1]),
      .dout    (filt_b)
   );

   qpd_filter u_filt_i (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .tick    (tick),
      .din     (st_ff.sync_i[1]),
      .dout    (filt_i)
   );

   // ****************************************************************
   // Filter clock and signal selection
   // ****************************************************************
   // The mask keeps the low bits of the free counter, giving one tick in every 2 to the power of the field clocks.
   // A divide field of zero gives a tick on every clock.
   // With the filters off, the synchronised pins feed the edge detectors directly.
   always_comb begin
      div_mask = `QPD_DIV_W'((9'h1 << st_ff.fdiv) - 9'h1);
      tick     = ((st_ff.div_cnt & div_mask) == div_mask);
      sel_a    = st_ff.foe ? filt_a : st_ff.sync_a[1];
      sel_b    = st_ff.foe ? filt_b : st_ff.sync_b[1];
      sel_i    = st_ff.foe ? filt_i : st_ff.sync_i[1];
      edge_a   = sel_a ^ st_ff.prev_a;
      edge_b   = sel_b ^ st_ff.prev_b;
      rise_a   = sel_a & ~st_ff.prev_a;
      rise_i   = sel_i & ~st_ff.prev_i;
   end

   // ****************************************************************
   // Mode decode and count step
   // ****************************************************************
   always_comb begin
      is_qei  = st_ff.mode[2];
      idx_rst = 1'b0;
      max_rst = 1'b0;
      step    = 1'b0;
      cnt_up  = 1'b1;
      // Modes 000, 010 and 011 never step the counter.
      // In x4 an A edge and a B edge in one cycle cancel, as no direction fits them.
      // After an A edge the count rises when A and B differ, after a B edge when they agree.
      case (st_ff.mode)
         `QPD_MODE_TIMER: begin
            max_rst = 1'b1;
            step    = rise_a;
            cnt_up  = tmr_dir;
         end
         `QPD_MODE_X2_IDX: begin
            idx_rst = 1'b1;
            step    = edge_a;
            cnt_up  = sel_a ^ sel_b;
         end
         `QPD_MODE_X2_MAX: begin
            max_rst = 1'b1;
            step    = edge_a;
            cnt_up  = sel_a ^ sel_b;
         end
         `QPD_MODE_X4_IDX: begin
            idx_rst = 1'b1;
            step    = edge_a ^ edge_b;
            cnt_up  = edge_a ? (sel_a ^ sel_b) : ~(sel_a ^ sel_b);
         end
         `QPD_MODE_X4_MAX: begin
            max_rst = 1'b1;
            step    = edge_a ^ edge_b;
            cnt_up  = edge_a ? (sel_a ^ sel_b) : ~(sel_a ^ sel_b);
         end
         default: begin
            step    = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Count arithmetic
   // ****************************************************************
   // Sleep stops only the count and the index events: the synchronisers and edge history keep
   // following the pins, so waking up brings no burst of false counts.
   always_comb begin
      tmr_dir = st_ff.dir_src ? sel_b : st_ff.dir_sw;
      step_ok = step & ~cpu_sleep;
      idx_ok  = is_qei & rise_i & ~cpu_sleep;
      pos_inc = st_ff.pos + 16'h0001;
      pos_dec = st_ff.pos - 16'h0001;
      wrap_up = max_rst & (st_ff.pos == st_ff.maxc);
      wrap_dn = max_rst & (st_ff.pos == 16'h0000);
   end

   // ****************************************************************
   // Bus strobes
   // ****************************************************************
   // The bus never waits, so a write lands at the edge that ends its access cycle.
   always_comb begin
      wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite;
      rd_setup = apb_req.psel & ~apb_req.penable;
   end

   // ****************************************************************
   // Register bus decode
   // ****************************************************************
   // Read data is captured in the setup cycle and stands through the access cycle.
   // In the encoder modes the direction bit reads the last counted direction.
   always_comb begin
      dir_rd   = is_qei ? st_ff.dir_stat : st_ff.dir_sw;
      rd_data  = 32'h0;
      rd_err   = 1'b0;
      case (apb_req.paddr)
         `QPD_OFF_CTRL: begin
            rd_data[`QPD_CTRL_DIR_BIT]                     = dir_rd;
            rd_data[`QPD_CTRL_MODE_HI:`QPD_CTRL_MODE_LO]   = st_ff.mode;
            rd_data[`QPD_CTRL_SRC_BIT]                     = st_ff.dir_src;
         end
         `QPD_OFF_FILT: begin
            rd_data[`QPD_FILT_OE_BIT]                      = st_ff.foe;
            rd_data[`QPD_FILT_DIV_HI:`QPD_FILT_DIV_LO]     = st_ff.fdiv;
         end
         `QPD_OFF_POS: begin
            rd_data[15:0] = st_ff.pos;
         end
         `QPD_OFF_MAX: begin
            rd_data[15:0] = st_ff.maxc;
         end
         `QPD_OFF_STAT: begin
            rd_data[`QPD_ST_W-1:0] = st_ff.stat;
         end
         `QPD_OFF_MASK: begin
            rd_data[`QPD_ST_W-1:0] = st_ff.mask;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      nxt_st          = st_ff;
      match_ev        = 1'b0;
      index_ev        = 1'b0;
      st_set          = '0;
      st_clr          = '0;

      // ****************************************************************
      // Synchronisers and edge history
      // ****************************************************************
      // Pins pass two flops before any logic sees them.
      nxt_st.sync_a   = {st_ff.sync_a[0], phase_a_input};
      nxt_st.sync_b   = {st_ff.sync_b[0], phase_b_input};
      nxt_st.sync_i   = {st_ff.sync_i[0], index_input};
      nxt_st.prev_a   = sel_a;
      nxt_st.prev_b   = sel_b;
      nxt_st.prev_i   = sel_i;
      nxt_st.div_cnt  = st_ff.div_cnt + `QPD_DIV_W'(1);

      // ****************************************************************
      // Position count
      // ****************************************************************
      // The count register is only touched by counting, by an index reset or by software.
      if (step_ok) begin
         if (is_qei) begin
            nxt_st.dir_stat = cnt_up;
         end
         if (cnt_up) begin
            if (wrap_up) begin
               nxt_st.pos = 16'h0000;
               match_ev   = 1'b1;
            end else begin
               nxt_st.pos = pos_inc;
            end
         end else begin
            if (wrap_dn) begin
               nxt_st.pos = st_ff.maxc;
               match_ev   = 1'b1;
            end else begin
               nxt_st.pos = pos_dec;
            end
         end
      end

      // ****************************************************************
      // Index pulse
      // ****************************************************************
      // In the index modes an index reset takes priority over a step in the same cycle.
      if (idx_ok) begin
         index_ev = 1'b1;
         if (idx_rst) begin
            nxt_st.pos = 16'h0000;
            match_ev   = 1'b1;
         end
      end

      // ****************************************************************
      // Status events
      // ****************************************************************
      // The match bit also marks an index reset, so one bit reports every reset of the count.
      st_set[`QPD_ST_MATCH] = match_ev;
      st_set[`QPD_ST_INDEX] = index_ev;

      // ****************************************************************
      // Software writes
      // ****************************************************************
      // A write to the count register wins over a count in the same cycle.
      if (wr_en) begin
         case (apb_req.paddr)
            `QPD_OFF_CTRL: begin
               nxt_st.mode    = apb_req.pwdata[`QPD_CTRL_MODE_HI:`QPD_CTRL_MODE_LO];
               nxt_st.dir_sw  = apb_req.pwdata[`QPD_CTRL_DIR_BIT];
               nxt_st.dir_src = apb_req.pwdata[`QPD_CTRL_SRC_BIT];
            end
            `QPD_OFF_FILT: begin
               nxt_st.foe  = apb_req.pwdata[`QPD_FILT_OE_BIT];
               nxt_st.fdiv = apb_req.pwdata[`QPD_FILT_DIV_HI:`QPD_FILT_DIV_LO];
            end
            `QPD_OFF_POS: begin
               nxt_st.pos = apb_req.pwdata[15:0];
            end
            `QPD_OFF_MAX: begin
               nxt_st.maxc = apb_req.pwdata[15:0];
            end
            `QPD_OFF_STAT: begin
               st_clr = apb_req.pwdata[`QPD_ST_W-1:0];
            end
            `QPD_OFF_MASK: begin
               nxt_st.mask = apb_req.pwdata[`QPD_ST_W-1:0];
            end
            default: begin
               st_clr = '0;
            end
         endcase
      end

      // A new event wins over a clear in the same cycle.
      nxt_st.stat = (st_ff.stat & ~st_clr) | st_set;

      // ****************************************************************
      // Read capture
      // ****************************************************************
      if (rd_setup) begin
         nxt_st.prdata  = rd_data;
         nxt_st.pslverr = rd_err;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         // Reset clears every field; those with a meaning of their own are named again.
         st_ff      <= '0;
         st_ff.mode <= `QPD_MODE_RST;
         st_ff.fdiv <= `QPD_FDIV_RST;
         st_ff.maxc <= `QPD_MAX_RST;
         st_ff.foe  <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // The bus answers with no wait state; pslverr stands only in the access cycle.
   // The interrupt is a level straight from the status and mask flops.
   assign apb_rsp.prdata  = st_ff.prdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = st_ff.pslverr & apb_req.psel & apb_req.penable;
   assign irq             = |(st_ff.stat & st_ff.mask);

endmodule

`default_nettype wire

// >>> qpd_defines.svh
`ifndef QPD_DEFINES_SVH
`define QPD_DEFINES_SVH

// ****************************************************************
// Register map and fields
// ****************************************************************
`define QPD_ADDR_W        12
`define QPD_OFF_CTRL      12'h000
`define QPD_OFF_FILT      12'h004
`define QPD_OFF_POS       12'h008
`define QPD_OFF_MAX       12'h00c
`define QPD_OFF_STAT      12'h010
`define QPD_OFF_MASK      12'h014
`define QPD_CTRL_DIR_BIT  11
`define QPD_CTRL_MODE_HI  10
`define QPD_CTRL_MODE_LO  8
`define QPD_CTRL_SRC_BIT  0
`define QPD_FILT_OE_BIT   7
`define QPD_FILT_DIV_HI   6
`define QPD_FILT_DIV_LO   4
`define QPD_ST_MATCH      0
`define QPD_ST_INDEX      1
`define QPD_ST_W          2

// ****************************************************************
// Mode encodings
// ****************************************************************
`define QPD_MODE_TIMER    3'h1
`define QPD_MODE_X2_IDX   3'h4
`define QPD_MODE_X2_MAX   3'h5
`define QPD_MODE_X4_IDX   3'h6
`define QPD_MODE_X4_MAX   3'h7

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define QPD_MODE_RST      3'h0
`define QPD_FDIV_RST      3'h0
`define QPD_MAX_RST       16'hffff
`define QPD_FILT_STABLE   3
`define QPD_DIV_W         8

`endif

// >>> qpd_pkg.sv
`default_nettype none
`include "qpd_defines.svh"

package qpd_pkg;

   typedef struct packed {
      logic                    psel;
      logic                    penable;
      logic                    pwrite;
      logic [`QPD_ADDR_W-1:0]  paddr;
      logic [31:0]             pwdata;
   } qpd_apb_req_t;

   typedef struct packed {
      logic [31:0]             prdata;
      logic                    pready;
      logic                    pslverr;
   } qpd_apb_rsp_t;

   typedef struct packed {
      logic [`QPD_FILT_STABLE-1:0] hist;
      logic                        out;
   } qpd_filt_st_t;

   typedef struct packed {
      logic [1:0]              sync_a;
      logic [1:0]              sync_b;
      logic [1:0]              sync_i;
      logic                    prev_a;
      logic                    prev_b;
      logic                    prev_i;
      logic [`QPD_DIV_W-1:0]   div_cnt;
      logic [2:0]              mode;
      logic                    dir_sw;
      logic                    dir_src;
      logic [2:0]              fdiv;
      logic                    foe;
      logic                    dir_stat;
      logic [15:0]             pos;
      logic [15:0]             maxc;
      logic [`QPD_ST_W-1:0]    stat;
      logic [`QPD_ST_W-1:0]    mask;
      logic [31:0]             prdata;
      logic                    pslverr;
   } qpd_st_t;

endpackage

`default_nettype wire

// >>> qpd_filter.sv
`default_nettype none
`include "qpd_defines.svh"

module qpd_filter (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic tick,
   input  wire logic din,
   output logic      dout
);
   import qpd_pkg::*;

   qpd_filt_st_t st_ff;
   qpd_filt_st_t nxt_st;
   logic [`QPD_FILT_STABLE-1:0] shifted;

   // ****************************************************************
   // Stability filter
   // ****************************************************************
   always_comb begin
      nxt_st  = st_ff;
      shifted = {st_ff.hist[`QPD_FILT_STABLE-2:0], din};
      if (tick) begin
         nxt_st.hist = shifted;
         if (&shifted) begin
            nxt_st.out = 1'b1;
         end else if (~|shifted) begin
            nxt_st.out = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.out;

endmodule

`default_nettype wire

// >>> qpd_enc_model.sv
`default_nettype none
module qpd_enc_model (
   input  wire logic sys_clk,
   output var logic  ph_a,
   output var logic  ph_b,
   output var logic  idx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] s = 2'h0;
   initial begin
      {ph_a, ph_b, idx} <= 3'h0;
   end
   // Each encoder state is held for eight clocks; forward steps have A leading B.
   task automatic step(input logic up);
      @(posedge sys_clk);
      s = up ? s + 2'h1 : s - 2'h1;
      ph_a <= s[1] ^ s[0];
      ph_b <= s[1];
      repeat (8) @(posedge sys_clk);
   endtask
   // Timer clock pulses on phase A, with phase B held as a direction level.
   task automatic pulse(input int n, input logic b);
      repeat (n) begin
         @(posedge sys_clk);
         ph_a <= 1'b0;
         ph_b <= b;
         repeat (8) @(posedge sys_clk);
         ph_a <= 1'b1;
         repeat (8) @(posedge sys_clk);
      end
   endtask
   task automatic idx_pulse(input int n);
      @(posedge sys_clk);
      idx <= 1'b1;
      repeat (n) @(posedge sys_clk);
      idx <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// >>> qpd_top_chk.sv
`default_nettype none
module qpd_top_chk (
   input wire logic                  sys_clk,
   input wire logic                  rst_b,
   input wire qpd_pkg::qpd_apb_req_t apb_req,
   input wire qpd_pkg::qpd_apb_rsp_t apb_rsp,
   input wire logic                  phase_a_input,
   input wire logic                  phase_b_input,
   input wire logic                  index_input,
   input wire logic                  cpu_sleep,
   input wire logic                  irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import qpd_pkg::*;
   logic acc;
   logic setup;
   logic unm;
   logic rd16;
   logic wm0;
   assign acc   = apb_req.psel && apb_req.penable;
   assign setup = apb_req.psel && !apb_req.penable;
   assign unm   = (apb_req.paddr[1:0] != 2'h0) || (apb_req.paddr > 12'h014);
   assign rd16  = acc && !apb_req.pwrite && (apb_req.paddr[11:3] == 9'h001);
   assign wm0   = acc && apb_req.pwrite && (apb_req.paddr == 12'h014) && (apb_req.pwdata[1:0] == 2'h0);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   property p_rdy; acc |-> apb_rsp.pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_err_unm; acc && unm |-> apb_rsp.pslverr; endproperty
   a_err_unm: assert property (p_err_unm) else $error("no slverr");
   property p_err_map; acc && !unm |-> !apb_rsp.pslverr; endproperty
   a_err_map: assert property (p_err_map) else $error("bad slverr");
   property p_err_acc; apb_rsp.pslverr |-> acc; endproperty
   a_err_acc: assert property (p_err_acc) else $error("stray slverr");
   property p_rd_unm; acc && unm && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0; endproperty
   a_rd_unm: assert property (p_rd_unm) else $error("hole data");
   property p_hold; !$past(setup) |-> $stable(apb_rsp.prdata); endproperty
   a_hold: assert property (p_hold) else $error("prdata moved");
   property p_hi0; rd16 |-> apb_rsp.prdata[31:16] == 16'h0; endproperty
   a_hi0: assert property (p_hi0) else $error("upper bits set");
   property p_rst_irq; $rose(rst_b) |-> !irq; endproperty
   a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
   property p_mask0; wm0 |=> !irq; endproperty
   a_mask0: assert property (p_mask0) else $error("irq not masked");
   c_read: cover property (acc && !apb_req.pwrite);
   c_err: cover property (apb_rsp.pslverr);
   c_irq: cover property ($rose(irq));
endmodule
bind qpd_top qpd_top_chk u_chk (
   .sys_clk(sys_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
   .index_input(index_input), .cpu_sleep(cpu_sleep), .irq(irq)
);
`default_nettype wire

// >>> qpd_top_bench.sv
`default_nettype none
module qpd_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import qpd_pkg::*;
   logic         sys_clk   = 1'b0;
   logic         rst_b;
   logic         cpu_sleep;
   logic         ph_a, ph_b, idx, irq, er;
   logic [31:0]  rd;
   qpd_apb_req_t req;
   qpd_apb_rsp_t rsp;
   int           n_errors  = 0;
   int           compares  = 0;
   int           cyc       = 0;
   always #12.5 sys_clk = ~sys_clk;
   qpd_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
      .phase_a_input(ph_a), .phase_b_input(ph_b), .index_input(idx),
      .cpu_sleep(cpu_sleep), .irq(irq));
   qpd_enc_model enc (.sys_clk(sys_clk), .ph_a(ph_a), .ph_b(ph_b), .idx(idx));
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= w;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge sys_clk);
      req.penable <= 1'b1;
      @(posedge sys_clk);
      while (rsp.pready !== 1'b1) @(posedge sys_clk);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(nm, e, rd);
   endtask
   task automatic ck_irq(input logic e);
      @(posedge sys_clk);
      cmp("irq", {31'h0, e}, {31'h0, irq});
   endtask
   task automatic t_regs;
      rc("ctrl", 12'h000, 32'h0);
      rc("filt", 12'h004, 32'h0);
      rc("pos", 12'h008, 32'h0);
      rc("max", 12'h00c, 32'hffff);
      rc("stat", 12'h010, 32'h0);
      rc("mask", 12'h014, 32'h0);
      rc("hole", 12'h018, 32'h0);
      cmp("err", 32'h1, {31'h0, er});
   endtask
   task automatic t_enc;
      wr(12'h000, 32'h600);
      repeat (4) enc.step(1'b1);
      rc("x4 up", 12'h008, 32'h4);
      repeat (2) enc.step(1'b0);
      rc("x4 dn", 12'h008, 32'h2);
      wr(12'h000, 32'h400);
      rc("swap", 12'h008, 32'h2);
      repeat (4) enc.step(1'b1);
      rc("x2 up", 12'h008, 32'h4);
      enc.idx_pulse(8);
      rc("x2 idx", 12'h008, 32'h0);
      rc("idx st", 12'h010, 32'h3);
      wr(12'h010, 32'h3);
   endtask
   task automatic t_max;
      wr(12'h00c, 32'h3);
      wr(12'h000, 32'h700);
      wr(12'h014, 32'h1);
      repeat (4) enc.step(1'b1);
      rc("wrap", 12'h008, 32'h0);
      ck_irq(1'b1);
      wr(12'h014, 32'h0);
      ck_irq(1'b0);
      wr(12'h010, 32'h1);
      wr(12'h014, 32'h1);
      ck_irq(1'b0);
      enc.step(1'b0);
      rc("under", 12'h008, 32'h3);
      cpu_sleep <= 1'b1;
      repeat (2) enc.step(1'b1);
      rc("sleep", 12'h008, 32'h3);
      cpu_sleep <= 1'b0;
      wr(12'h000, 32'h500);
      wr(12'h010, 32'h1);
      repeat (2) enc.step(1'b1);
      rc("x2 wrap", 12'h008, 32'h0);
      rc("x2 match", 12'h010, 32'h1);
      enc.step(1'b0);
      rc("x2 dn", 12'h008, 32'h3);
   endtask
   task automatic t_filt;
      wr(12'h000, 32'h600);
      wr(12'h004, 32'h80);
      repeat (8) @(posedge sys_clk);
      wr(12'h008, 32'h5);
      enc.idx_pulse(2);
      rc("flt 2", 12'h008, 32'h5);
      wr(12'h004, 32'h90);
      enc.idx_pulse(4);
      rc("div 1", 12'h008, 32'h5);
      wr(12'h004, 32'h80);
      enc.idx_pulse(4);
      rc("div 0", 12'h008, 32'h0);
      wr(12'h008, 32'h5);
      wr(12'h004, 32'h0);
      enc.idx_pulse(2);
      rc("raw", 12'h008, 32'h0);
   endtask
   task automatic t_timer;
      wr(12'h00c, 32'h5);
      wr(12'h000, 32'h900);
      wr(12'h008, 32'h0);
      enc.pulse(3, 1'b0);
      rc("tmr up", 12'h008, 32'h3);
      wr(12'h000, 32'h100);
      enc.pulse(1, 1'b0);
      rc("sw dn", 12'h008, 32'h2);
      wr(12'h000, 32'h101);
      enc.pulse(2, 1'b1);
      rc("pin up", 12'h008, 32'h4);
      enc.pulse(1, 1'b0);
      rc("pin dn", 12'h008, 32'h3);
      wr(12'h010, 32'h3);
      enc.pulse(3, 1'b1);
      rc("period", 12'h008, 32'h0);
      rc("match", 12'h010, 32'h1);
   endtask
   initial begin
      rst_b     <= 1'b0;
      cpu_sleep <= 1'b0;
      req       <= '0;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs;
      t_enc;
      t_max;
      t_filt;
      t_timer;
      give_verdict;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict;
      end
   end
   task automatic give_verdict;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
endmodule
`default_nettype wire
